// file: core/bmm_ctrl.sv
// boot memory map control: decode, map-mode and connect bits, registers
// Functional notes
// [RQ1] reset clears map-mode and host-connect bits
// [RQ2] boot mode: rom at 0000 and 8000
// [RQ3] boot mode: ram read/write in data 0000-1FFF
// [RQ4] data FD80-FFFF always mapped register space
// [RQ5] normal mode: rom 8000, ram code 0000
// [RQ6] first fetch at 0000 from rom
// [RQ7] firmware loads eeprom or usb into ram
// [RQ8] setting map-mode switches to normal map
// [RQ9] host-connect set only after map switch
// [RQ10] port high driven two cycles, then released
// [RQ11] select pins pick 48 MHz or crystal
// [RQ12] map-mode cannot be cleared by write
// [RQ13] code-space writes blocked in normal mode
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
module bmm_ctrl #(
	parameter int PORT_WIDTH = 8,
	parameter int OD_CYCLES = bmm_pkg::OD_HIGH_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// processor side
	input wire bmm_pkg::bmm_req_s cpu_req,
	output bmm_pkg::bmm_sel_s cpu_sel,
	output logic [15:0] reset_fetch_addr,
	// pins
	input wire logic clock_select_a,
	input wire logic clock_select_b,
	output bmm_pkg::bmm_clk_src_e clk_src,
	output logic clk_reserved,
	output logic host_connect,
	input wire logic [PORT_WIDTH-1:0] port_i,
	output logic [PORT_WIDTH-1:0] port_o,
	output logic [PORT_WIDTH-1:0] port_oe
);
	import bmm_pkg::*;

	// =====================================================
	// control state
	logic map_mode_q, map_mode_d;
	logic host_connect_q, host_connect_d;
	logic [PORT_WIDTH-1:0] port_out_q, port_out_d;
	logic blocked_wr_q, blocked_wr_d;
	logic conn_refused_q, conn_refused_d;
	bmm_boot_e boot_q, boot_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [PORT_WIDTH-1:0] port_in_q;
	logic [1:0] clk_sel_q;
	bmm_sel_s sel;

	logic wr_ctrl, wr_port, wr_fault, busy;
	assign busy = avs_read | avs_write;
	// writes land at the edge where waitrequest is seen low
	assign wr_ctrl = avs_write && ack_q && avs_address == REG_CTRL && avs_byteenable[0];
	assign wr_port = avs_write && ack_q && avs_address == REG_PORT_OUT && avs_byteenable[0];
	assign wr_fault = avs_write && ack_q && avs_address == REG_FAULT && avs_byteenable[0];

	// =====================================================
	// address decode
	always_comb begin
		sel = '0;
		sel.offset = cpu_req.addr;
		if (cpu_req.valid) begin
			if (cpu_req.code_space) begin
				if (!map_mode_q) begin
					if (bmm_in_range(cpu_req.addr, ROM_BASE_LO, ROM_LAST_LO)) begin
						sel.rom = 1'b1; // RQ2
						sel.offset = cpu_req.addr - ROM_BASE_LO;
					end else if (bmm_in_range(cpu_req.addr, ROM_BASE_HI, ROM_LAST_HI)) begin
						sel.rom = 1'b1; // RQ2
						sel.offset = cpu_req.addr - ROM_BASE_HI;
					end
				end else begin
					if (bmm_in_range(cpu_req.addr, ROM_BASE_HI, ROM_LAST_HI)) begin
						sel.rom = 1'b1; // RQ5
						sel.offset = cpu_req.addr - ROM_BASE_HI;
					end else if (bmm_in_range(cpu_req.addr, RAM_BASE, RAM_LAST)) begin
						sel.ram = 1'b1; // RQ5
						sel.offset = cpu_req.addr - RAM_BASE;
					end
				end
				if (cpu_req.write) begin
					// no code-space writes reach memory in either mode
					sel.blocked = map_mode_q; // RQ13
					sel.rom = 1'b0;
					sel.ram = 1'b0;
				end
			end else begin
				if (bmm_in_range(cpu_req.addr, MMR_BASE, MMR_LAST)) begin
					sel.mapped_register_space = 1'b1; // RQ4
					sel.offset = cpu_req.addr - MMR_BASE;
				end else if (!map_mode_q && bmm_in_range(cpu_req.addr, RAM_BASE, RAM_LAST)) begin
					sel.ram = 1'b1; // RQ3
					sel.offset = cpu_req.addr - RAM_BASE;
				end
			end
		end
	end

	assign cpu_sel = sel;
	assign reset_fetch_addr = RESET_FETCH_ADDR; // RQ6

	// =====================================================
	// register next values
	always_comb begin
		map_mode_d = map_mode_q;
		host_connect_d = host_connect_q;
		port_out_d = port_out_q;
		blocked_wr_d = blocked_wr_q;
		conn_refused_d = conn_refused_q;
		boot_d = boot_q;
		ack_d = busy && !ack_q;
		rdata_d = rdata_q;
		if (wr_ctrl) begin
			// map-mode only sets; a written zero is ignored
			if (avs_writedata[CTRL_MAP_MODE_BIT]) begin
				map_mode_d = 1'b1; // RQ12 RQ8
			end
			// connect honoured only once the map is switched
			if (map_mode_q) begin
				host_connect_d = avs_writedata[CTRL_HOST_CONNECT_BIT]; // RQ9
			end else if (avs_writedata[CTRL_HOST_CONNECT_BIT]) begin
				conn_refused_d = 1'b1; // RQ9
			end
		end
		if (wr_port) begin
			port_out_d = avs_writedata[PORT_WIDTH-1:0];
		end
		// set wins over clear
		if (wr_fault) begin
			blocked_wr_d = blocked_wr_q & ~avs_writedata[0];
			conn_refused_d = conn_refused_q & ~avs_writedata[1];
		end
		if (sel.blocked) begin
			blocked_wr_d = 1'b1; // RQ13
		end
		if (wr_ctrl && !map_mode_q && avs_writedata[CTRL_HOST_CONNECT_BIT]) begin
			conn_refused_d = 1'b1;
		end
		case (boot_q)
			BMM_BOOT_LOAD: if (map_mode_q) boot_d = BMM_BOOT_MAPPED; // RQ7
			BMM_BOOT_MAPPED: if (host_connect_q) boot_d = BMM_BOOT_CONNECTED;
			BMM_BOOT_CONNECTED: if (!host_connect_q) boot_d = BMM_BOOT_MAPPED;
			default: boot_d = BMM_BOOT_LOAD;
		endcase
		if (avs_read && !ack_q) begin
			case (avs_address)
				REG_CTRL: begin
					rdata_d = '0;
					rdata_d[CTRL_MAP_MODE_BIT] = map_mode_q;
					rdata_d[CTRL_HOST_CONNECT_BIT] = host_connect_q;
				end
				REG_STATUS: begin
					rdata_d = '0;
					rdata_d[STAT_CLK_SEL_LSB +: 2] = clk_sel_q;
					rdata_d[STAT_MAP_MODE_BIT] = map_mode_q;
					rdata_d[STAT_HOST_CONNECT_BIT] = host_connect_q;
					rdata_d[STAT_BOOT_STATE_LSB +: 2] = boot_q;
				end
				REG_PORT_OUT: rdata_d = 32'(port_out_q);
				REG_PORT_IN: rdata_d = 32'(port_in_q);
				REG_FAULT: rdata_d = {30'h0000_0000, conn_refused_q, blocked_wr_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			map_mode_q <= RST_MAP_MODE; // RQ1
			host_connect_q <= RST_HOST_CONNECT; // RQ1
			port_out_q <= PORT_WIDTH'(RST_PORT_OUT);
			blocked_wr_q <= 1'b0;
			conn_refused_q <= 1'b0;
			boot_q <= BMM_BOOT_LOAD;
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			map_mode_q <= map_mode_d;
			host_connect_q <= host_connect_d;
			port_out_q <= port_out_d;
			blocked_wr_q <= blocked_wr_d;
			conn_refused_q <= conn_refused_d;
			boot_q <= boot_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// =====================================================
	// pin sampling and clock select
	always_ff @(posedge clk) begin
		if (rst) begin
			port_in_q <= '0;
			clk_sel_q <= 2'b11;
		end else if (ce) begin
			port_in_q <= port_i;
			clk_sel_q <= {clock_select_a, clock_select_b};
		end
	end

	assign clk_src = bmm_clk_src_e'(clk_sel_q); // RQ11
	assign clk_reserved = clk_sel_q[1] ^ clk_sel_q[0]; // RQ11
	assign host_connect = host_connect_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = busy && !ack_q;

	// =====================================================
	// general-purpose port
	bmm_od_port #(
		.WIDTH(PORT_WIDTH),
		.HIGH_CYCLES(OD_CYCLES)
	) u_port (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.out_val(port_out_q),
		.pin_o(port_o),
		.pin_oe(port_oe)
	);

endmodule : bmm_ctrl

// file: core/bmm_pkg.sv
// package: constants and types for the boot memory map control block
package bmm_pkg;

	// memory map figures
	localparam logic [15:0] ROM_BASE_LO = 16'h0000;
	localparam logic [15:0] ROM_LAST_LO = 16'h17FF;
	localparam logic [15:0] ROM_BASE_HI = 16'h8000;
	localparam logic [15:0] ROM_LAST_HI = 16'h97FF;
	localparam logic [15:0] RAM_BASE = 16'h0000;
	localparam logic [15:0] RAM_LAST = 16'h1FFF;
	localparam logic [15:0] MMR_BASE = 16'hFD80;
	localparam logic [15:0] MMR_LAST = 16'hFFFF;
	localparam logic [15:0] RESET_FETCH_ADDR = 16'h0000;
	localparam int ROM_DEPTH = 6144;
	localparam int RAM_DEPTH = 8192;

	// avalon register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PORT_OUT = 8'h08;
	localparam logic [7:0] REG_PORT_IN = 8'h0C;
	localparam logic [7:0] REG_FAULT = 8'h10;

	// control and status register fields
	localparam int CTRL_MAP_MODE_BIT = 0;
	localparam int CTRL_HOST_CONNECT_BIT = 1;
	localparam int STAT_CLK_SEL_LSB = 0;
	localparam int STAT_MAP_MODE_BIT = 2;
	localparam int STAT_HOST_CONNECT_BIT = 3;
	localparam int STAT_BOOT_STATE_LSB = 4;

	// reset values
	localparam logic RST_MAP_MODE = 1'b0;
	localparam logic RST_HOST_CONNECT = 1'b0;
	localparam logic [7:0] RST_PORT_OUT = 8'hFF;

	// open-drain high drive time
	localparam int CLK_MHZ = 250;
	localparam int OD_HIGH_CYCLES = 2;

	// clock source selections from the two select pins
	typedef enum logic [1:0] {
		BMM_CLK_EXT48 = 2'b00,
		BMM_CLK_TEST_A = 2'b01,
		BMM_CLK_TEST_B = 2'b10,
		BMM_CLK_XTAL12 = 2'b11
	} bmm_clk_src_e;

	// boot sequence progress as seen by the block
	typedef enum logic [1:0] {
		BMM_BOOT_LOAD,
		BMM_BOOT_MAPPED,
		BMM_BOOT_CONNECTED
	} bmm_boot_e;

	// processor bus request
	typedef struct packed {
		logic valid;
		logic code_space;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bmm_req_s;

	// decoded target of a processor access
	typedef struct packed {
		logic rom;
		logic ram;
		logic mapped_register_space;
		logic blocked;
		logic [15:0] offset;
	} bmm_sel_s;

	// address range test
	function automatic logic bmm_in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		bmm_in_range = (a >= lo) && (a <= hi);
	endfunction : bmm_in_range

endpackage : bmm_pkg

// file: core/bmm_od_port.sv
// open-drain output driver for one general-purpose port
module bmm_od_port #(
	parameter int WIDTH = 8,
	parameter int HIGH_CYCLES = bmm_pkg::OD_HIGH_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] out_val,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe
);
	import bmm_pkg::*;

	localparam int CW = $clog2(HIGH_CYCLES + 1);
	localparam logic [CW-1:0] HIGH_LAST = CW'(HIGH_CYCLES);

	logic [WIDTH-1:0] prev_q, prev_d;
	logic [CW-1:0] cnt_q [WIDTH], cnt_d [WIDTH];
	logic [WIDTH-1:0] o_q, o_d, oe_q, oe_d;

	// =====================================================
	// per-bit drive timing
	always_comb begin
		prev_d = out_val;
		for (int i = 0; i < WIDTH; i++) begin
			cnt_d[i] = cnt_q[i];
			o_d[i] = out_val[i];
			oe_d[i] = 1'b0;
			if (!out_val[i]) begin
				oe_d[i] = 1'b1; // RQ10
				cnt_d[i] = '0;
			end else if (!prev_q[i]) begin
				cnt_d[i] = CW'(1); // RQ10
				oe_d[i] = 1'b1;
			end else if (cnt_q[i] != '0 && cnt_q[i] < HIGH_LAST) begin
				cnt_d[i] = cnt_q[i] + CW'(1);
				oe_d[i] = 1'b1;
			end else begin
				cnt_d[i] = '0; // RQ10
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= '1;
			o_q <= '1;
			oe_q <= '0;
			for (int i = 0; i < WIDTH; i++) cnt_q[i] <= '0;
		end else if (ce) begin
			prev_q <= prev_d;
			o_q <= o_d;
			oe_q <= oe_d;
			for (int i = 0; i < WIDTH; i++) cnt_q[i] <= cnt_d[i];
		end
	end

	assign pin_o = o_q;
	assign pin_oe = oe_q;

endmodule : bmm_od_port

// file: testbench/bmm_cpu_model.sv
// processor core model issuing code and data requests
module bmm_cpu_model
	import bmm_pkg::*;
(
	input wire logic clk,
	output bmm_pkg::bmm_req_s cpu_req
);
	// ====
	// request driver
	initial cpu_req = '0;
	// request held until the next call
	task go(input logic c, input logic w, input logic [15:0] a);
		@(posedge clk);
		cpu_req <= '{valid: 1'b1, code_space: c, write: w, addr: a, wdata: ~a[7:0]};
	endtask : go
endmodule : bmm_cpu_model

// file: testbench/bmm_ctrl_properties.sv
// port assertions for the boot memory map control block
module bmm_ctrl_properties
	import bmm_pkg::*;
#(
	parameter int PORT_WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire bmm_pkg::bmm_req_s cpu_req,
	input wire bmm_pkg::bmm_sel_s cpu_sel,
	input wire logic clock_select_a,
	input wire logic clock_select_b,
	input wire bmm_pkg::bmm_clk_src_e clk_src,
	input wire logic clk_reserved,
	input wire logic host_connect,
	input wire logic [PORT_WIDTH-1:0] port_o,
	input wire logic [PORT_WIDTH-1:0] port_oe
);
	// ====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_connect_reset: assert property ($fell(rst) |-> !host_connect)
		else $error("connect set after reset");
	a_rom_high: assert property (cpu_req.valid && cpu_req.code_space && !cpu_req.write
		&& cpu_req.addr >= 16'h8000 && cpu_req.addr <= 16'h97FF |-> cpu_sel.rom && !cpu_sel.ram)
		else $error("rom mirror missed");
	a_low_code: assert property (cpu_req.valid && cpu_req.code_space && !cpu_req.write
		&& cpu_req.addr <= 16'h17FF |-> cpu_sel.rom != cpu_sel.ram)
		else $error("low code not one target");
	a_mmr_decode: assert property (cpu_req.valid && !cpu_req.code_space
		&& cpu_req.addr >= 16'hFD80 |-> cpu_sel.mapped_register_space && !cpu_sel.ram)
		else $error("register space missed");
	a_code_write: assert property (cpu_req.valid && cpu_req.code_space && cpu_req.write
		|-> !cpu_sel.rom && !cpu_sel.ram)
		else $error("code write reached memory");
	a_clk_follow: assert property (!$past(rst) && $past(ce)
		|-> clk_src == $past({clock_select_a, clock_select_b})
		&& clk_reserved == $past(clock_select_a ^ clock_select_b))
		else $error("clock select wrong");
	a_od_high: assert property ($rose(port_o[0]) |-> port_oe[0] ##1 port_oe[0]
		##1 !port_oe[0])
		else $error("high drive not two cycles");
	a_od_low: assert property (!port_o[0] |-> port_oe[0])
		else $error("low not driven");
endmodule : bmm_ctrl_properties
bind bmm_ctrl bmm_ctrl_properties #(.PORT_WIDTH(PORT_WIDTH)) u_props (.clk(clk), .rst(rst),
	.ce(ce), .cpu_req(cpu_req), .cpu_sel(cpu_sel), .clock_select_a(clock_select_a),
	.clock_select_b(clock_select_b), .clk_src(clk_src), .clk_reserved(clk_reserved),
	.host_connect(host_connect), .port_o(port_o), .port_oe(port_oe));

// file: testbench/bmm_ctrl_tb.sv
// self-checking bench for the boot memory map control block
module bmm_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bmm_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic clock_select_a = 1'b1, clock_select_b = 1'b1, avs_waitrequest, clk_reserved;
	logic host_connect;
	logic [7:0] avs_address = 8'h00, port_i = 8'hA5, port_o, port_oe;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rdata;
	logic [15:0] reset_fetch_addr;
	bmm_req_s cpu_req;
	bmm_sel_s cpu_sel;
	bmm_clk_src_e clk_src;
	int errors = 0, check_count = 0;
	bmm_ctrl uut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_sel(cpu_sel),
		.reset_fetch_addr(reset_fetch_addr), .clock_select_a(clock_select_a),
		.clock_select_b(clock_select_b), .clk_src(clk_src), .clk_reserved(clk_reserved),
		.host_connect(host_connect), .port_i(port_i), .port_o(port_o), .port_oe(port_oe));
	bmm_cpu_model cpu (.clk(clk), .cpu_req(cpu_req));
	// ====
	// helpers
	initial forever #2 clk = ~clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rdata, e);
	endtask : rd
	// expected flags rom ram mmr blocked, then offset when rom, ram or mmr
	task dec(input logic c, input logic w, input logic [15:0] a, input logic [19:0] e);
		cpu.go(c, w, a);
		@(negedge clk);
		chk(32'({cpu_sel.rom, cpu_sel.ram, cpu_sel.mapped_register_space, cpu_sel.blocked}), 32'(e[19:16]));
		if (e[19:17] != 3'b000)
			chk(32'(cpu_sel.offset), 32'(e[15:0]));
	endtask : dec
	task end_sim;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		#20000;
		errors++;
		end_sim();
	end
	// ====
	// tests
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk(32'(reset_fetch_addr), 32'h0000_0000);
		rd(REG_CTRL, 32'h0000_0000);
		rd(REG_STATUS, 32'h0000_0003);
		rd(REG_PORT_OUT, 32'h0000_00FF);
		rd(REG_PORT_IN, 32'h0000_00A5);
		rd(8'h20, 32'h0000_0000);
		dec(1'b1, 1'b0, 16'h0000, 20'h8_0000);
		dec(1'b1, 1'b0, 16'h97FF, 20'h8_17FF);
		dec(1'b0, 1'b1, 16'h1FFF, 20'h4_1FFF);
		dec(1'b0, 1'b0, 16'hFD80, 20'h2_0000);
		dec(1'b1, 1'b0, 16'h1800, 20'h0_0000);
		bus(1'b1, REG_CTRL, 32'h0000_0002);
		rd(REG_STATUS, 32'h0000_0003);
		rd(REG_FAULT, 32'h0000_0002);
		bus(1'b1, REG_FAULT, 32'h0000_0002);
		rd(REG_FAULT, 32'h0000_0000);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		rd(REG_STATUS, 32'h0000_0017);
		dec(1'b1, 1'b0, 16'h0000, 20'h4_0000);
		dec(1'b1, 1'b0, 16'h8000, 20'h8_0000);
		dec(1'b0, 1'b0, 16'h0000, 20'h0_0000);
		dec(1'b0, 1'b0, 16'hFFFF, 20'h2_027F);
		dec(1'b1, 1'b1, 16'h0000, 20'h1_0000);
		rd(REG_FAULT, 32'h0000_0001);
		bus(1'b1, REG_CTRL, 32'h0000_0000);
		rd(REG_CTRL, 32'h0000_0001);
		bus(1'b1, REG_CTRL, 32'h0000_0003);
		@(negedge clk);
		chk(32'(host_connect), 32'h0000_0001);
		rd(REG_STATUS, 32'h0000_002F);
		bus(1'b1, REG_PORT_OUT, 32'h0000_005A);
		repeat (3) @(negedge clk);
		chk(32'({port_o, port_oe}), 32'h0000_5AA5);
		bus(1'b1, REG_PORT_OUT, 32'h0000_00FF);
		repeat (3) @(negedge clk);
		chk(32'({port_o, port_oe}), 32'h0000_FFA5);
		repeat (2) @(negedge clk);
		chk(32'({port_o, port_oe}), 32'h0000_FF00);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{clock_select_a, clock_select_b} <= 2'(i);
			repeat (3) @(negedge clk);
			chk(32'(clk_src), 32'(i));
			chk(32'(clk_reserved), 32'(i == 1 || i == 2));
		end
		// clock enable low freezes the select register
		@(posedge clk);
		ce <= 1'b0;
		clock_select_a <= 1'b0;
		repeat (3) @(negedge clk);
		chk(32'(clk_src), 32'h0000_0003);
		@(posedge clk);
		ce <= 1'b1;
		repeat (2) @(negedge clk);
		chk(32'(clk_src), 32'h0000_0001);
		chk(32'(clk_reserved), 32'h0000_0001);
		end_sim();
	end
endmodule : bmm_ctrl_tb
